// *** strap_two_pkg.sv ***
package strap_two_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] STRAP_ONE_INDEX = 8'h09;
    localparam logic [7:0] STRAP_TWO_INDEX = 8'h0a;
    localparam logic [11:0] STRAP_ONE_ADDR = 12'(STRAP_ONE_INDEX) << 2;
    localparam logic [11:0] STRAP_TWO_ADDR = 12'(STRAP_TWO_INDEX) << 2;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int ONE_DONE_BIT = 15;
    localparam int ONE_MDIX_HI = 6;
    localparam int ONE_MDIX_LO = 5;
    localparam int TWO_STORED_MSB = 13;
    localparam int TWO_FAST_LINK_BIT = 6;
    localparam int TWO_FD_OPT_BIT = 5;
    localparam int TWO_LED_QUAL_BIT = 4;
    localparam int TWO_ISOLATE_BIT = 3;
    localparam int TWO_IDLE_ERR_BIT = 2;
    localparam int TWO_ODD_DIS_BIT = 1;
    localparam int TWO_RMII_CLK_BIT = 0;
    localparam logic [13:0] STRAP_TWO_RESET = 14'h0004;
    localparam logic [1:0] MDIX_MODE_RESET = 2'h0;

    // Link state as the link-control logic reports it.
    typedef struct packed {
        logic up;
        logic speed_100;
        logic partner_forced_100;
        logic ieee_full_duplex;
    } link_status_t;

    // Decoded strap options that take effect after the internal reset.
    typedef struct packed {
        logic fast_link_up;
        logic forced_full_duplex_option;
        logic qualified_link_indicator;
        logic isolate_hd_100;
        logic idle_rx_error_enable;
        logic odd_nibble_disable;
        logic rmii_rx_on_receive_clock;
    } strap_cfg_t;

endpackage : strap_two_pkg

// *** phy_soft_strap_bank_two.sv ***
`timescale 1ns/1ns
// Overview of operation
// R01 - Processor writes straps, then sets done flag.
// R02 - Done flag pulses reset, latches strap values.
// R03 - Bits 15:14 ignore writes, read zero.
// R04 - Bit 6 selects fast parallel-detect link-up.
// R05 - Auto crossover modes force fast link-up bit.
// R06 - Bit 5 forces full duplex with forced partner.
// R07 - Bit 5 clear uses standard duplex resolution.
// R08 - Bit 4 qualifies link indicator to 100FD.
// R09 - Bit 3 isolates MII on 100 half duplex.
// R10 - Bit 2 enables idle receive error, resets one.
// R11 - Bit 1 set suppresses odd-nibble transmit error.
// R12 - Bit 1 clear extends enable, flags error.
// R13 - Bit 0 set references receive clock output.
// R14 - Bit 0 clear references reference clock input.
// R15 - Bits 13:7 store and read back only.
module phy_soft_strap_bank_two (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [strap_two_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire strap_two_pkg::link_status_t link_status,
    input wire logic idle_symbol_error,
    input wire logic tx_nibble_tick,
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    output logic strap_reset_pulse,
    output strap_two_pkg::strap_cfg_t active_cfg,
    output logic fast_parallel_detect,
    output logic link_full_duplex,
    output logic link_indicator,
    output logic mii_isolate,
    output logic rx_error_flag,
    output logic tx_en_out,
    output logic tx_er_out,
    output logic rmii_rx_ref_select
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Matches a word-aligned byte address against a register byte address.
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        addr_hit = (addr[11:2] == reg_addr[11:2]);
    endfunction : addr_hit

    logic [13:0] strap_two;
    logic [1:0] mdix_mode;
    logic config_done;
    wire hit_one = addr_hit(paddr, strap_two_pkg::STRAP_ONE_ADDR);
    wire hit_two = addr_hit(paddr, strap_two_pkg::STRAP_TWO_ADDR);
    wire mapped = hit_one | hit_two;
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire write_one = access_done & pwrite & hit_one;
    wire write_two = access_done & pwrite & hit_two;
    wire done_request = write_one & pwdata[strap_two_pkg::ONE_DONE_BIT];
    // The crossover mode being written counts at once, so a single write that
    // selects an auto mode and sets the done flag still latches fast link-up.
    wire [1:0] next_mdix_mode = write_one
        ? pwdata[strap_two_pkg::ONE_MDIX_HI:strap_two_pkg::ONE_MDIX_LO] : mdix_mode;
    wire auto_mdix = |next_mdix_mode; // [R05]
    wire [31:0] read_one = {16'h0000, config_done, 8'h00, mdix_mode, 5'h00};
    wire [31:0] read_two = {18'h00000, strap_two}; // [R03]
    wire [31:0] next_prdata = hit_one ? read_one : (hit_two ? read_two : 32'h0000_0000);

    // Zero wait states; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Read data is captured in the setup cycle so it stands from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Strap registers
    // ------------------------------------------------------------------

    // Bits 15:14 are never stored, so writes to them simply vanish. Bits 13:7
    // are kept only for read-back. While an auto crossover mode is selected
    // the fast link-up bit is forced on, winning over a software clear.
    wire [13:0] written_two = write_two ? pwdata[13:0] : strap_two; // [R03] [R15]
    wire [13:0] next_strap_two = written_two
        | (14'(auto_mdix) << strap_two_pkg::TWO_FAST_LINK_BIT); // [R05]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_two <= strap_two_pkg::STRAP_TWO_RESET; // [R10]
        end else begin
            strap_two <= next_strap_two;
        end
    end

    // Crossover mode and the completion flag of the first strap register.
    // The flag stays set once written; only a device reset clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdix_mode <= strap_two_pkg::MDIX_MODE_RESET;
            config_done <= 1'b0;
        end else begin
            mdix_mode <= next_mdix_mode;
            if (done_request) begin
                config_done <= 1'b1; // [R01]
            end
        end
    end

    // ------------------------------------------------------------------
    // Internal reset pulse and option latch
    // ------------------------------------------------------------------

    // The options in force change only on the internal reset pulse, so the
    // processor may rewrite straps freely before declaring them complete.
    wire strap_two_pkg::strap_cfg_t next_cfg = '{
        fast_link_up: next_strap_two[strap_two_pkg::TWO_FAST_LINK_BIT],
        forced_full_duplex_option: next_strap_two[strap_two_pkg::TWO_FD_OPT_BIT],
        qualified_link_indicator: next_strap_two[strap_two_pkg::TWO_LED_QUAL_BIT],
        isolate_hd_100: next_strap_two[strap_two_pkg::TWO_ISOLATE_BIT],
        idle_rx_error_enable: next_strap_two[strap_two_pkg::TWO_IDLE_ERR_BIT],
        odd_nibble_disable: next_strap_two[strap_two_pkg::TWO_ODD_DIS_BIT],
        rmii_rx_on_receive_clock: next_strap_two[strap_two_pkg::TWO_RMII_CLK_BIT]
    };

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_reset_pulse <= 1'b0;
            // The options in force after reset mirror the register's reset value.
            active_cfg <= strap_two_pkg::strap_cfg_t'(
                strap_two_pkg::STRAP_TWO_RESET[6:0]); // [R10]
        end else begin
            strap_reset_pulse <= done_request; // [R02]
            if (done_request) begin
                active_cfg <= next_cfg; // [R02]
            end
        end
    end

    // ------------------------------------------------------------------
    // Link option outputs
    // ------------------------------------------------------------------

    // Full duplex is forced against a forced 100 partner only when the
    // option is on; otherwise the standard resolution passes through.
    wire forced_fd = active_cfg.forced_full_duplex_option & link_status.partner_forced_100
        & link_status.speed_100; // [R06]
    wire next_full_duplex = forced_fd | link_status.ieee_full_duplex; // [R06] [R07]
    wire full_100 = link_status.up & link_status.speed_100 & next_full_duplex;
    wire half_100 = link_status.up & link_status.speed_100 & ~next_full_duplex;
    wire next_indicator = active_cfg.qualified_link_indicator ? full_100 : link_status.up; // [R08]
    wire next_isolate = active_cfg.isolate_hd_100 & half_100; // [R09]
    wire next_rx_error = active_cfg.idle_rx_error_enable & idle_symbol_error; // [R10]

    // Registered so every link-facing output comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_parallel_detect <= 1'b0;
            link_full_duplex <= 1'b0;
            link_indicator <= 1'b0;
            mii_isolate <= 1'b0;
            rx_error_flag <= 1'b0;
            rmii_rx_ref_select <= 1'b0;
        end else begin
            fast_parallel_detect <= active_cfg.fast_link_up; // [R04]
            link_full_duplex <= next_full_duplex;
            link_indicator <= next_indicator;
            mii_isolate <= next_isolate;
            rx_error_flag <= next_rx_error;
            rmii_rx_ref_select <= active_cfg.rmii_rx_on_receive_clock; // [R13] [R14]
        end
    end

    // ------------------------------------------------------------------
    // Odd-nibble transmit handling
    // ------------------------------------------------------------------

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND,
        TX_EXTEND
    } tx_state_t;

    tx_state_t tx_state;
    tx_state_t next_tx_state;
    logic nibble_odd;

    // A frame ending after an odd count of nibbles leaves half a byte; unless
    // suppressed, it is stretched one nibble and marked as an error.
    wire tx_falls_odd = (tx_state == TX_SEND) & ~tx_en_in & nibble_odd;
    wire start_extend = tx_falls_odd & ~active_cfg.odd_nibble_disable; // [R11] [R12]

    always_comb begin
        next_tx_state = tx_state;
        unique case (tx_state)
            TX_IDLE: begin
                if (tx_en_in) begin
                    next_tx_state = TX_SEND;
                end
            end
            TX_SEND: begin
                if (start_extend) begin
                    next_tx_state = TX_EXTEND;
                end else if (!tx_en_in) begin
                    next_tx_state = TX_IDLE;
                end
            end
            TX_EXTEND: begin
                next_tx_state = tx_en_in ? TX_SEND : TX_IDLE;
            end
        endcase
    end

    // All transmit state advances only on the nibble tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            nibble_odd <= 1'b0;
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
        end else if (tx_nibble_tick) begin
            tx_state <= next_tx_state;
            nibble_odd <= tx_en_in ? ~nibble_odd : 1'b0;
            tx_en_out <= tx_en_in | start_extend; // [R12]
            tx_er_out <= tx_er_in | start_extend; // [R12]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
        (setup_phase && hit_two) |=> (prdata[31:14] == 18'h00000))
        else $error("reserved strap bits read nonzero");

    latch_on_done_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
        done_request |=> (strap_reset_pulse && active_cfg == $past(next_cfg)))
        else $error("strap values not latched on done pulse");

    pulse_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
        strap_reset_pulse |-> ($past(done_request) && config_done))
        else $error("internal reset pulse without done write");

    fast_link_auto_a: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
        auto_mdix |=> strap_two[strap_two_pkg::TWO_FAST_LINK_BIT])
        else $error("fast link-up bit not forced in auto crossover");

    fast_link_out_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
        ##1 fast_parallel_detect == $past(active_cfg.fast_link_up))
        else $error("fast parallel detect output wrong");

    forced_duplex_a: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
        (active_cfg.forced_full_duplex_option && link_status.partner_forced_100
            && link_status.speed_100) |=> link_full_duplex)
        else $error("forced partner not run in full duplex");

    ieee_duplex_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
        !active_cfg.forced_full_duplex_option |=> (link_full_duplex
            == $past(link_status.ieee_full_duplex)))
        else $error("duplex differs from standard resolution");

    led_qualify_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
        (active_cfg.qualified_link_indicator && link_status.up && !link_status.speed_100)
            |=> !link_indicator)
        else $error("qualified indicator lit on non 100 link");

    isolate_hd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        ##1 mii_isolate == $past(active_cfg.isolate_hd_100 && half_100))
        else $error("MII isolation does not match half duplex 100");

    idle_error_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (idle_symbol_error && !active_cfg.idle_rx_error_enable) |=> !rx_error_flag)
        else $error("idle receive error flagged while disabled");

    odd_extend_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (tx_nibble_tick && tx_falls_odd && !active_cfg.odd_nibble_disable)
            |=> (tx_en_out && tx_er_out && tx_state == TX_EXTEND))
        else $error("odd nibble end not extended with error");

    odd_suppress_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (tx_nibble_tick && tx_falls_odd && active_cfg.odd_nibble_disable && !tx_er_in)
            |=> (!tx_en_out && !tx_er_out))
        else $error("odd nibble error raised while suppressed");

    rmii_ref_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        ##1 rmii_rx_ref_select == $past(active_cfg.rmii_rx_on_receive_clock))
        else $error("receive reference select wrong");

    stored_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        write_two |=> (strap_two[13:7] == $past(pwdata[13:7])))
        else $error("reserved writable bits not stored");

    // Options hold between pulses; link and transmit outputs follow their inputs.
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
        !done_request |=> $stable(active_cfg))
        else $error("options changed without done write");

    pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
        strap_reset_pulse |=> !strap_reset_pulse)
        else $error("internal reset pulse longer than one cycle");

    fast_link_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
        (done_request && auto_mdix) |=> active_cfg.fast_link_up)
        else $error("fast link-up not latched in auto crossover");

    fast_link_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
        (write_two && !auto_mdix) |=> (strap_two[strap_two_pkg::TWO_FAST_LINK_BIT]
            == $past(pwdata[strap_two_pkg::TWO_FAST_LINK_BIT])))
        else $error("fast link-up bit not written");

    led_any_link_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
        !active_cfg.qualified_link_indicator |=> (link_indicator == $past(link_status.up)))
        else $error("plain indicator does not follow link");

    rx_error_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        active_cfg.idle_rx_error_enable |=> (rx_error_flag == $past(idle_symbol_error)))
        else $error("idle receive error not passed while enabled");

    ref_receive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        active_cfg.rmii_rx_on_receive_clock |=> rmii_rx_ref_select)
        else $error("receive clock reference not selected");

    ref_crystal_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        !active_cfg.rmii_rx_on_receive_clock |=> !rmii_rx_ref_select)
        else $error("reference clock input not selected");

    tx_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (tx_nibble_tick && !start_extend) |=> (tx_en_out == $past(tx_en_in)
            && tx_er_out == $past(tx_er_in)))
        else $error("transmit outputs do not follow inputs");

    extend_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (tx_nibble_tick && tx_state == TX_EXTEND && !tx_en_in && !tx_er_in)
            |=> (!tx_en_out && !tx_er_out))
        else $error("odd nibble extension longer than one nibble");

endmodule : phy_soft_strap_bank_two

// *** strap_host.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Processor model on the register bus
// ----------------------------------------------------------------------
// It runs one transfer at a time and holds it until pready is seen high.
module strap_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [strap_two_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus is idle from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // Setup, then access until pready; data and error are taken at that edge.
    // Released lines show the inverse value so stale data never looks valid.
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask : xfer
endmodule : strap_host

// *** phy_soft_strap_bank_two_test.sv ***
`timescale 1ns/1ns
module phy_soft_strap_bank_two_test;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    strap_two_pkg::link_status_t link_status;
    strap_two_pkg::strap_cfg_t active_cfg;
    logic idle_symbol_error, tx_nibble_tick, tx_en_in, tx_er_in, strap_reset_pulse;
    logic fast_parallel_detect, link_full_duplex, link_indicator, mii_isolate;
    logic rx_error_flag, tx_en_out, tx_er_out, rmii_rx_ref_select;
    int err_total = 0;
    int check_count = 0;
    localparam logic [11:0] ONE = strap_two_pkg::STRAP_ONE_ADDR;
    localparam logic [11:0] TWO = strap_two_pkg::STRAP_TWO_ADDR;

    strap_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    phy_soft_strap_bank_two dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_status(link_status),
        .idle_symbol_error(idle_symbol_error), .tx_nibble_tick(tx_nibble_tick),
        .tx_en_in(tx_en_in), .tx_er_in(tx_er_in), .strap_reset_pulse(strap_reset_pulse),
        .active_cfg(active_cfg), .fast_parallel_detect(fast_parallel_detect),
        .link_full_duplex(link_full_duplex), .link_indicator(link_indicator),
        .mii_isolate(mii_isolate), .rx_error_flag(rx_error_flag), .tx_en_out(tx_en_out),
        .tx_er_out(tx_er_out), .rmii_rx_ref_select(rmii_rx_ref_select));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        host_u.xfer(1'b1, addr, data, rd, err);
    endtask : wr

    task automatic rdc(input logic [11:0] addr, input logic [31:0] exp);
        host_u.xfer(1'b0, addr, 32'h0, rd, err);
        chk("read data", rd, exp);
    endtask : rdc

    // Sets the done flag; the pulse and new options must show in the next cycle.
    task automatic done(input logic [6:0] cfg);
        wr(ONE, 32'h8000);
        #1;
        chk("reset pulse", {31'h0, strap_reset_pulse}, 32'h1);
        chk("options", {25'h0, active_cfg}, {25'h0, cfg});
        @(posedge pclk);
        #1;
        chk("pulse end", {31'h0, strap_reset_pulse}, 32'h0);
    endtask : done

    // Outputs are read two edges later, one edge past their stated latency.
    task automatic lnk(input logic [3:0] st, input logic [5:0] exp);
        @(posedge pclk);
        link_status <= st;
        idle_symbol_error <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("link outputs", {26'h0, fast_parallel_detect, link_full_duplex, link_indicator,
            mii_isolate, rx_error_flag, rmii_rx_ref_select}, {26'h0, exp});
    endtask : lnk

    task automatic nib(input logic en, input logic [1:0] exp);
        @(posedge pclk);
        tx_nibble_tick <= 1'b1;
        tx_en_in <= en;
        @(posedge pclk);
        tx_nibble_tick <= 1'b0;
        #1;
        chk("transmit", {30'h0, tx_en_out, tx_er_out}, {30'h0, exp});
    endtask : nib

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // The run needs about 90 cycles; a hang is cut well after that.
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        stop_test();
    end

    initial begin
        presetn = 1'b0;
        link_status = 4'h0;
        idle_symbol_error = 1'b0;
        tx_nibble_tick = 1'b0;
        tx_en_in = 1'b0;
        tx_er_in = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset options", {25'h0, active_cfg}, 32'h4);
        rdc(TWO, 32'h4);
        wr(TWO, 32'hffff_ffff);
        #1;
        chk("options held", {25'h0, active_cfg}, 32'h4);
        rdc(TWO, 32'h3fff);
        done(7'h7f);
        lnk(4'b1110, 6'b111011);
        lnk(4'b1100, 6'b100111);
        host_u.xfer(1'b1, 12'h02c, 32'h0, rd, err);
        chk("unmapped error", {31'h0, err}, 32'h1);
        rdc(TWO, 32'h3fff);
        wr(TWO, 32'h0);
        done(7'h00);
        lnk(4'b1110, 6'b001000);
        lnk(4'b1101, 6'b011000);
        nib(1'b1, 2'b10);
        nib(1'b1, 2'b10);
        nib(1'b1, 2'b10);
        nib(1'b0, 2'b11);
        nib(1'b0, 2'b00);
        wr(ONE, 32'h0020);
        repeat (2) @(posedge pclk);
        rdc(TWO, 32'h0040);
        wr(ONE, 32'h0000);
        wr(TWO, 32'h0002);
        done(7'h02);
        nib(1'b1, 2'b10);
        nib(1'b1, 2'b10);
        nib(1'b1, 2'b10);
        nib(1'b0, 2'b00);
        // One write that picks an auto crossover mode and sets done latches fast link-up.
        wr(ONE, 32'h8040);
        #1;
        chk("auto fast link", {31'h0, active_cfg.fast_link_up}, 32'h1);
        rdc(ONE, 32'h8040);
        // A reset in mid-run clears the done flag and restores every default.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("options after reset", {25'h0, active_cfg}, 32'h4);
        rdc(TWO, 32'h4);
        rdc(ONE, 32'h0);
        stop_test();
    end
endmodule : phy_soft_strap_bank_two_test
